//--- hdl/tft_timing_pkg.sv
package tft_timing_pkg;

   localparam int unsigned H_W            = 12;
   localparam int unsigned V_W            = 11;
   localparam int unsigned H_LSB          = 16;

   localparam logic [11:0] OFF_SYNC_SIZE  = 12'h008;
   localparam logic [11:0] OFF_BACK_PORCH = 12'h00C;
   localparam logic [11:0] OFF_ACTIVE     = 12'h010;
   localparam logic [11:0] OFF_TOTAL      = 12'h014;
   localparam logic [11:0] OFF_CONTROL    = 12'h018;
   localparam logic [11:0] OFF_RELOAD     = 12'h024;
   localparam logic [11:0] OFF_BACKGROUND = 12'h02C;
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h034;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h038;
   localparam logic [11:0] OFF_POSITION   = 12'h044;

   localparam logic [11:0] LAYER_BASE     = 12'h084;
   localparam logic [11:0] LAYER_STRIDE   = 12'h080;
   localparam int unsigned LAYER_NUM      = 2;
   localparam int unsigned LAYER_REGS     = 10;

   localparam logic [3:0]  LY_CTRL        = 4'h0;
   localparam logic [3:0]  LY_WIN_H       = 4'h1;
   localparam logic [3:0]  LY_WIN_V       = 4'h2;
   localparam logic [3:0]  LY_FORMAT      = 4'h3;
   localparam logic [3:0]  LY_ALPHA       = 4'h4;
   localparam logic [3:0]  LY_DEFAULT     = 4'h5;
   localparam logic [3:0]  LY_BLEND       = 4'h6;
   localparam logic [3:0]  LY_FB_ADDR     = 4'h7;
   localparam logic [3:0]  LY_FB_LENGTH   = 4'h8;
   localparam logic [3:0]  LY_FB_LINES    = 4'h9;

   localparam int unsigned CTRL_EN_BIT    = 0;
   localparam int unsigned CTRL_DISP_BIT  = 1;
   localparam int unsigned CTRL_PCPOL_BIT = 28;
   localparam int unsigned CTRL_DEPOL_BIT = 29;
   localparam int unsigned CTRL_VSPOL_BIT = 30;
   localparam int unsigned CTRL_HSPOL_BIT = 31;
   localparam int unsigned IRQ_GLOBAL_BIT = 0;
   localparam int unsigned IRQ_UNDER_BIT  = 1;
   localparam int unsigned IRQ_TERR_BIT   = 2;
   localparam int unsigned RELOAD_IMM_BIT = 0;
   localparam int unsigned RELOAD_VB_BIT  = 1;
   localparam int unsigned LY_EN_BIT      = 0;
   localparam int unsigned BF1_LSB        = 8;
   localparam logic [2:0]  BF_PIXEL_ALPHA = 3'h6;

   localparam logic [31:0] TIMING_MASK    = 32'h0FFF_07FF;
   localparam logic [31:0] CONTROL_MASK   = 32'hF000_0003;
   localparam logic [31:0] IRQ_MASK       = 32'h0000_0007;
   localparam logic [31:0] COLOR_MASK     = 32'h00FF_FFFF;
   localparam logic [31:0] TIMING_RST     = 32'h0000_0000;
   localparam logic [31:0] CONTROL_RST    = 32'h0000_0000;
   localparam logic [31:0] BACKGROUND_RST = 32'h0000_0000;
   localparam logic [31:0] IRQ_RST        = 32'h0000_0000;
   localparam logic [31:0] LAYER_RST      = 32'h0000_0000;

   typedef enum logic [1:0] {
      RELOAD_IDLE = 2'b00,
      RELOAD_WAIT = 2'b01
   } reload_state_t;

endpackage : tft_timing_pkg

//--- hdl/sync2.sv
`timescale 1ns/1ps
module sync2 (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic d,
   output logic      q
);

   logic meta;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : sync2

//--- hdl/timing_counter.sv
`timescale 1ns/1ps
module timing_counter #(
   parameter int unsigned WIDTH = 12
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             enable,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] limit,
   output logic      [WIDTH-1:0] count,
   output logic                  wrap
);

   logic [WIDTH-1:0] next_count;

   // A count already past a newly shortened limit wraps on its next enabled step.
   assign wrap = enable & (count >= limit);

   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = '0;
      end else if (wrap) begin
         next_count = '0;
      end else if (enable) begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule : timing_counter

//--- hdl/tft_panel_timing_and_layers.sv
`timescale 1ns/1ps
module tft_panel_timing_and_layers (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pixelClockIn,
   input  wire logic [31:0] firstLayerPixel,
   input  wire logic [31:0] secondLayerPixel,
   input  wire logic        fifoUnderrunEvent,
   input  wire logic        transferErrorEvent,
   output logic [7:0]       panelRed,
   output logic [7:0]       panelGreen,
   output logic [7:0]       panelBlue,
   output logic             panel_hsync_out,
   output logic             panel_vsync_out,
   output logic             panel_data_enable_out,
   output logic             panel_pixel_clock_out,
   output logic             panel_display_on_pin,
   output logic             irqOut
);

   ////////////////////////////////////////////////////////////////////////////////

   logic [31:0]                   syncSize;
   logic [31:0]                   backPorch;
   logic [31:0]                   activeSize;
   logic [31:0]                   totalSize;
   logic [31:0]                   control;
   logic [31:0]                   background;
   logic [31:0]                   irqEnable;
   logic [31:0]                   irqStatus;
   logic [31:0]                   layerReg    [tft_timing_pkg::LAYER_NUM][tft_timing_pkg::LAYER_REGS];
   logic [31:0]                   layerShadow [tft_timing_pkg::LAYER_NUM][tft_timing_pkg::LAYER_REGS];
   tft_timing_pkg::reload_state_t reloadState;
   logic [31:0]                   next_syncSize;
   logic [31:0]                   next_backPorch;
   logic [31:0]                   next_activeSize;
   logic [31:0]                   next_totalSize;
   logic [31:0]                   next_control;
   logic [31:0]                   next_background;
   logic [31:0]                   next_irqEnable;
   logic [31:0]                   next_irqStatus;
   logic [31:0]                   next_layerReg    [tft_timing_pkg::LAYER_NUM][tft_timing_pkg::LAYER_REGS];
   logic [31:0]                   next_layerShadow [tft_timing_pkg::LAYER_NUM][tft_timing_pkg::LAYER_REGS];
   tft_timing_pkg::reload_state_t next_reloadState;
   logic [31:0]                   next_prdata;
   logic                          next_irqOut;

   logic                          pixClkSynced;
   logic                          pixClkLast;
   logic                          pixEn;
   logic                          dispOn;
   logic [tft_timing_pkg::H_W-1:0] hCount;
   logic [tft_timing_pkg::V_W-1:0] vCount;
   logic                          hWrap;
   logic                          vblankStart;
   logic                          wrEn;
   logic                          rdSetup;
   logic [5:0]                    wrDec;
   logic [5:0]                    rdDec;

   logic                          hsActive;
   logic                          vsActive;
   logic                          deActive;
   logic [23:0]                   mixColor;
   logic [7:0]                    next_panelRed;
   logic [7:0]                    next_panelGreen;
   logic [7:0]                    next_panelBlue;
   logic                          next_hsync;
   logic                          next_vsync;
   logic                          next_de;
   logic                          next_pclk;
   logic                          next_dispPin;

   ////////////////////////////////////////////////////////////////////////////////

   // Returns hit, layer and register index of a layer register address.
   function automatic logic [5:0] layerDecode(input logic [11:0] a);
      logic [11:0] rel;
      logic [5:0]  r;
      r = 6'h00;
      for (int l = 0; l < int'(tft_timing_pkg::LAYER_NUM); l++) begin
         rel = a - (tft_timing_pkg::LAYER_BASE + 12'(l) * tft_timing_pkg::LAYER_STRIDE);
         if (rel < 12'(tft_timing_pkg::LAYER_REGS * 4) && rel[1:0] == 2'b00) begin
            r = {1'b1, 1'(l), rel[5:2]};
         end
      end
      return r;
   endfunction : layerDecode

   // Tells whether an address selects any register.
   function automatic logic addrMapped(input logic [11:0] a);
      logic [5:0] d;
      d = layerDecode(a);
      return d[5] || a == tft_timing_pkg::OFF_SYNC_SIZE || a == tft_timing_pkg::OFF_BACK_PORCH
         || a == tft_timing_pkg::OFF_ACTIVE || a == tft_timing_pkg::OFF_TOTAL
         || a == tft_timing_pkg::OFF_CONTROL || a == tft_timing_pkg::OFF_RELOAD
         || a == tft_timing_pkg::OFF_BACKGROUND || a == tft_timing_pkg::OFF_IRQ_ENABLE
         || a == tft_timing_pkg::OFF_IRQ_STATUS || a == tft_timing_pkg::OFF_POSITION;
   endfunction : addrMapped

   // Mixes one color channel by an alpha of 0 to 255.
   function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] fg,
                                      input logic [7:0] bg);
      logic [15:0] s;
      s = 16'(a) * 16'(fg) + 16'(8'hFF - a) * 16'(bg);
      return s[15:8];
   endfunction : mix

   // Tells whether the current position lies inside a layer window.
   function automatic logic inWindow(input logic [11:0] h, input logic [10:0] v,
                                     input logic [31:0] winH, input logic [31:0] winV);
      return h >= winH[11:0] && h <= winH[27:16] && v >= winV[10:0] && v <= winV[26:16];
   endfunction : inWindow

   ////////////////////////////////////////////////////////////////////////////////

   // The pixel clock arrives from outside and is resynchronised before use.
   sync2 pixClkSync (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .d      (pixelClockIn),
      .q      (pixClkSynced)
   );

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pixClkLast <= 1'b0;
      end else begin
         pixClkLast <= pixClkSynced;
      end
   end

   // Counters step on the falling input edge so the panel edge sits mid-pixel.
   assign pixEn  = pixClkLast & ~pixClkSynced;
   assign dispOn = control[tft_timing_pkg::CTRL_EN_BIT];

   timing_counter #(.WIDTH(tft_timing_pkg::H_W)) hCounter (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .enable (pixEn & dispOn),
      .clear  (~dispOn),
      .limit  (totalSize[27:16]),
      .count  (hCount),
      .wrap   (hWrap)
   );

   timing_counter #(.WIDTH(tft_timing_pkg::V_W)) vCounter (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .enable (hWrap),
      .clear  (~dispOn),
      .limit  (totalSize[10:0]),
      .count  (vCount),
      .wrap   ()
   );

   assign vblankStart = hWrap & (vCount == activeSize[10:0]);

   ////////////////////////////////////////////////////////////////////////////////

   assign wrEn    = psel & penable & pwrite;
   assign rdSetup = psel & ~penable & ~pwrite;
   assign wrDec   = layerDecode(paddr);
   assign rdDec   = wrDec;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addrMapped(paddr);

   always_comb begin
      next_syncSize    = syncSize;
      next_backPorch   = backPorch;
      next_activeSize  = activeSize;
      next_totalSize   = totalSize;
      next_control     = control;
      next_background  = background;
      next_irqEnable   = irqEnable;
      next_irqStatus   = irqStatus;
      next_layerReg    = layerReg;
      next_layerShadow = layerShadow;
      next_reloadState = reloadState;
      next_prdata      = prdata;
      if (wrEn) begin
         if (paddr == tft_timing_pkg::OFF_SYNC_SIZE) begin
            next_syncSize = pwdata & tft_timing_pkg::TIMING_MASK;
         end else if (paddr == tft_timing_pkg::OFF_BACK_PORCH) begin
            next_backPorch = pwdata & tft_timing_pkg::TIMING_MASK;
         end else if (paddr == tft_timing_pkg::OFF_ACTIVE) begin
            next_activeSize = pwdata & tft_timing_pkg::TIMING_MASK;
         end else if (paddr == tft_timing_pkg::OFF_TOTAL) begin
            next_totalSize = pwdata & tft_timing_pkg::TIMING_MASK;
         end else if (paddr == tft_timing_pkg::OFF_CONTROL) begin
            next_control = pwdata & tft_timing_pkg::CONTROL_MASK;
         end else if (paddr == tft_timing_pkg::OFF_BACKGROUND) begin
            next_background = pwdata & tft_timing_pkg::COLOR_MASK;
         end else if (paddr == tft_timing_pkg::OFF_IRQ_ENABLE) begin
            next_irqEnable = pwdata & tft_timing_pkg::IRQ_MASK;
         end else if (paddr == tft_timing_pkg::OFF_IRQ_STATUS) begin
            next_irqStatus = irqStatus & ~pwdata;
         end else if (paddr == tft_timing_pkg::OFF_RELOAD) begin
            if (pwdata[tft_timing_pkg::RELOAD_IMM_BIT]) begin
               next_layerShadow = layerReg;
               next_reloadState = tft_timing_pkg::RELOAD_IDLE;
            end else if (pwdata[tft_timing_pkg::RELOAD_VB_BIT]) begin
               next_reloadState = tft_timing_pkg::RELOAD_WAIT;
            end
         end else if (wrDec[5]) begin
            next_layerReg[wrDec[4]][wrDec[3:0]] = pwdata;
         end
      end
      case (reloadState)
         tft_timing_pkg::RELOAD_IDLE: begin
         end
         tft_timing_pkg::RELOAD_WAIT: begin
            if (vblankStart) begin
               next_layerShadow = layerReg;
               next_reloadState = tft_timing_pkg::RELOAD_IDLE;
            end
         end
         default: begin
            next_reloadState = tft_timing_pkg::RELOAD_IDLE;
         end
      endcase
      // New events win over a same-cycle clear.
      if (fifoUnderrunEvent) begin
         next_irqStatus[tft_timing_pkg::IRQ_UNDER_BIT] = 1'b1;
      end
      if (transferErrorEvent) begin
         next_irqStatus[tft_timing_pkg::IRQ_TERR_BIT] = 1'b1;
      end
      if (rdSetup) begin
         if (paddr == tft_timing_pkg::OFF_SYNC_SIZE) begin
            next_prdata = syncSize;
         end else if (paddr == tft_timing_pkg::OFF_BACK_PORCH) begin
            next_prdata = backPorch;
         end else if (paddr == tft_timing_pkg::OFF_ACTIVE) begin
            next_prdata = activeSize;
         end else if (paddr == tft_timing_pkg::OFF_TOTAL) begin
            next_prdata = totalSize;
         end else if (paddr == tft_timing_pkg::OFF_CONTROL) begin
            next_prdata = control;
         end else if (paddr == tft_timing_pkg::OFF_BACKGROUND) begin
            next_prdata = background;
         end else if (paddr == tft_timing_pkg::OFF_IRQ_ENABLE) begin
            next_prdata = irqEnable;
         end else if (paddr == tft_timing_pkg::OFF_IRQ_STATUS) begin
            next_prdata = irqStatus;
         end else if (paddr == tft_timing_pkg::OFF_RELOAD) begin
            next_prdata = {30'h0000_0000, reloadState == tft_timing_pkg::RELOAD_WAIT, 1'b0};
         end else if (paddr == tft_timing_pkg::OFF_POSITION) begin
            next_prdata = {4'h0, hCount, 5'h00, vCount};
         end else if (rdDec[5]) begin
            next_prdata = layerReg[rdDec[4]][rdDec[3:0]];
         end else begin
            next_prdata = 32'h0000_0000;
         end
      end
      next_irqOut = irqEnable[tft_timing_pkg::IRQ_GLOBAL_BIT]
                    & |(irqStatus & irqEnable & ~32'h0000_0001);
   end

   // A single reset clears every domain the block has at once.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         syncSize    <= tft_timing_pkg::TIMING_RST;
         backPorch   <= tft_timing_pkg::TIMING_RST;
         activeSize  <= tft_timing_pkg::TIMING_RST;
         totalSize   <= tft_timing_pkg::TIMING_RST;
         control     <= tft_timing_pkg::CONTROL_RST;
         background  <= tft_timing_pkg::BACKGROUND_RST;
         irqEnable   <= tft_timing_pkg::IRQ_RST;
         irqStatus   <= tft_timing_pkg::IRQ_RST;
         layerReg    <= '{default: '{default: tft_timing_pkg::LAYER_RST}};
         layerShadow <= '{default: '{default: tft_timing_pkg::LAYER_RST}};
         reloadState <= tft_timing_pkg::RELOAD_IDLE;
         prdata      <= 32'h0000_0000;
         irqOut      <= 1'b0;
      end else begin
         syncSize    <= next_syncSize;
         backPorch   <= next_backPorch;
         activeSize  <= next_activeSize;
         totalSize   <= next_totalSize;
         control     <= next_control;
         background  <= next_background;
         irqEnable   <= next_irqEnable;
         irqStatus   <= next_irqStatus;
         layerReg    <= next_layerReg;
         layerShadow <= next_layerShadow;
         reloadState <= next_reloadState;
         prdata      <= next_prdata;
         irqOut      <= next_irqOut;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   assign hsActive = hCount <= syncSize[27:16];
   assign vsActive = vCount <= syncSize[10:0];
   assign deActive = hCount > backPorch[27:16] && hCount <= activeSize[27:16]
                     && vCount > backPorch[10:0] && vCount <= activeSize[10:0];

   always_comb begin
      logic [7:0] alpha;
      logic [31:0] src;
      alpha    = 8'h00;
      src      = 32'h0000_0000;
      mixColor = background[23:0];
      for (int l = 0; l < int'(tft_timing_pkg::LAYER_NUM); l++) begin
         src   = (l == 0) ? firstLayerPixel : secondLayerPixel;
         alpha = layerShadow[l][tft_timing_pkg::LY_ALPHA][7:0];
         if (layerShadow[l][tft_timing_pkg::LY_BLEND][tft_timing_pkg::BF1_LSB +: 3]
             == tft_timing_pkg::BF_PIXEL_ALPHA) begin
            alpha = mix(alpha, src[31:24], 8'h00);
         end
         if (layerShadow[l][tft_timing_pkg::LY_CTRL][tft_timing_pkg::LY_EN_BIT]
             && inWindow(hCount, vCount, layerShadow[l][tft_timing_pkg::LY_WIN_H],
                         layerShadow[l][tft_timing_pkg::LY_WIN_V])) begin
            mixColor = {mix(alpha, src[23:16], mixColor[23:16]),
                        mix(alpha, src[15:8], mixColor[15:8]),
                        mix(alpha, src[7:0], mixColor[7:0])};
         end
      end
   end

   always_comb begin
      next_panelRed   = (dispOn & deActive) ? mixColor[23:16] : 8'h00;
      next_panelGreen = (dispOn & deActive) ? mixColor[15:8] : 8'h00;
      next_panelBlue  = (dispOn & deActive) ? mixColor[7:0] : 8'h00;
      next_hsync      = (dispOn & hsActive) == control[tft_timing_pkg::CTRL_HSPOL_BIT];
      next_vsync      = (dispOn & vsActive) == control[tft_timing_pkg::CTRL_VSPOL_BIT];
      next_de         = (dispOn & deActive) == control[tft_timing_pkg::CTRL_DEPOL_BIT];
      next_pclk       = pixClkSynced ^ control[tft_timing_pkg::CTRL_PCPOL_BIT];
      next_dispPin    = control[tft_timing_pkg::CTRL_DISP_BIT];
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         panelRed              <= 8'h00;
         panelGreen            <= 8'h00;
         panelBlue             <= 8'h00;
         panel_hsync_out       <= 1'b1;
         panel_vsync_out       <= 1'b1;
         panel_data_enable_out <= 1'b1;
         panel_pixel_clock_out <= 1'b0;
         panel_display_on_pin  <= 1'b0;
      end else begin
         panelRed              <= next_panelRed;
         panelGreen            <= next_panelGreen;
         panelBlue             <= next_panelBlue;
         panel_hsync_out       <= next_hsync;
         panel_vsync_out       <= next_vsync;
         panel_data_enable_out <= next_de;
         panel_pixel_clock_out <= next_pclk;
         panel_display_on_pin  <= next_dispPin;
      end
   end

endmodule : tft_panel_timing_and_layers

//--- dv/tft_panel_asserts.sv
`timescale 1ns/1ps
module tft_panel_asserts (
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pixelClockIn,
   input wire logic        panel_hsync_out,
   input wire logic        panel_vsync_out,
   input wire logic        panel_data_enable_out,
   input wire logic        panel_pixel_clock_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   property p_rdy; pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_acc; pslverr |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("stray error");
   property p_bad; psel && penable && paddr == 12'h004 |-> pslverr; endproperty
   a_bad: assert property (p_bad) else $error("hole accepted");
   property p_ok; psel && penable && paddr == 12'h014 |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("total refused");
   property p_clk; $rose(pixelClockIn) |-> ##[2:5] $changed(panel_pixel_clock_out); endproperty
   a_clk: assert property (p_clk) else $error("clock lost");
   property p_hs; $changed(panel_hsync_out) |=> $stable(panel_hsync_out); endproperty
   a_hs: assert property (p_hs) else $error("hsync glitch");
   property p_vs; $changed(panel_vsync_out) |=> $stable(panel_vsync_out); endproperty
   a_vs: assert property (p_vs) else $error("vsync glitch");
   property p_de; $changed(panel_data_enable_out) |=> $stable(panel_data_enable_out); endproperty
   a_de: assert property (p_de) else $error("enable glitch");
endmodule : tft_panel_asserts
bind tft_panel_timing_and_layers tft_panel_asserts chk (.*);

//--- dv/tft_panel_model.sv
`timescale 1ns/1ps
module tft_panel_model (
   output logic       pixelClockIn = 1'b0,
   input  wire logic  panel_pixel_clock_out,
   input  wire logic  panel_hsync_out,
   input  wire logic  panel_data_enable_out,
   input  wire logic [7:0] panelBlue,
   output int         lineDe,
   output logic [7:0] lastBlue
);
   int cnt = 0;
   always #62.5 pixelClockIn = ~pixelClockIn;
   always @(posedge panel_pixel_clock_out) begin
      if (panel_hsync_out) cnt <= 0;
      else if (panel_data_enable_out) cnt <= cnt + 1;
      if (panel_hsync_out && cnt != 0) lineDe <= cnt;
      if (panel_data_enable_out) lastBlue <= panelBlue;
   end
endmodule : tft_panel_model

//--- dv/tft_panel_timing_and_layers_tb_top.sv
`timescale 1ns/1ps
module tft_panel_timing_and_layers_tb_top;
   logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic fifoUnderrunEvent = 1'b0, transferErrorEvent = 1'b0, pixelClockIn, pready, pslverr;
   logic panel_hsync_out, panel_vsync_out, panel_data_enable_out, panel_pixel_clock_out;
   logic panel_display_on_pin, irqOut;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, firstLayerPixel = 32'h0, secondLayerPixel = 32'h0, prdata, rd;
   logic [7:0] panelRed, panelGreen, panelBlue, lastBlue;
   int lineDe, miscompares = 0, nChecks = 0;
   localparam logic [76:0] ROWS [9] = '{{12'h02C, 65'h0}, {12'h084, 65'h0}, {12'h004, 65'h0},
      {12'h008, 65'h1_0000_0000_0000_0000}, {12'h00C, 65'h1_0002_0001_0002_0001},
      {12'h010, 65'h1_0006_0003_0006_0003}, {12'h014, 65'h1_F009_F804_0009_0004},
      {12'h02C, 65'h1_FFAB_CDEF_00AB_CDEF}, {12'h10C, 65'h1_5A5A_A5A5_5A5A_A5A5}};
   localparam logic [32:0] IRQ [4] = '{{32'h1, 1'b0}, {32'h3, 1'b1}, {32'h3, 1'b0}, {32'h5, 1'b1}};
   always #5 ref_clk = ~ref_clk;
   tft_panel_timing_and_layers DUT (.*);
   tft_panel_model panel (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) $display("Error %0t: got %h, want %h", $time, got, exp);
      if (got !== exp) miscompares++;
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n = 0;
      {psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
      @(posedge ref_clk) penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 9);
      if (n == 9) chk(32'h0, 32'h1);
      if (n == 9) give_verdict();
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge ref_clk);
   endtask : xfer
   initial begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i][64]) xfer(ROWS[i][76:65], 1'b1, ROWS[i][63:32]);
         xfer(ROWS[i][76:65], 1'b0, 32'h0);
         chk(rd, ROWS[i][31:0]);
         chk({31'h0, err}, {31'h0, ROWS[i][76:65] == 12'h004});
      end
      xfer(12'h02C, 1'b1, 32'h0000_00FF);
      xfer(12'h018, 1'b1, 32'hF000_0003);
      repeat (1500) @(posedge ref_clk);
      chk(32'(lineDe), 32'h4);
      chk({24'h0, lastBlue}, 32'hFF);
      chk({31'h0, panel_display_on_pin}, 32'h1);
      {fifoUnderrunEvent, transferErrorEvent} <= 2'b11;
      @(posedge ref_clk) {fifoUnderrunEvent, transferErrorEvent} <= 2'b00;
      foreach (IRQ[i]) begin
         if (i == 2) xfer(12'h038, 1'b1, 32'h2);
         xfer(12'h034, 1'b1, IRQ[i][32:1]);
         repeat (2) @(posedge ref_clk);
         chk({31'h0, irqOut}, {31'h0, IRQ[i][0]});
      end
      // Mid-run reset must bring background, control and irqOut back to their reset values.
      arst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      xfer(12'h02C, 1'b0, 32'h0);
      chk(rd, 32'h0);
      xfer(12'h018, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irqOut}, 32'h0);
      give_verdict();
   end
endmodule : tft_panel_timing_and_layers_tb_top
